// >>> logic/ccs_pkg.sv
package ccs_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned QUICK_MEAS_MS    = 240;
  localparam int unsigned ZERO_DELAY_MS    = 250;
  localparam int unsigned QUICK_MEAS_CYC   = CLK_HZ / 1000 * QUICK_MEAS_MS;
  localparam int unsigned ZERO_DELAY_CYC   = CLK_HZ / 1000 * ZERO_DELAY_MS;
  localparam int unsigned SECOND_CYC       = CLK_HZ;

  // ==========================================================================
  // Setting defaults and sizes
  // ==========================================================================
  localparam logic [13:0] INTERVAL_DFLT    = 14'h0001;
  localparam logic [13:0] END_TIME_DFLT    = 14'h0064;
  localparam logic [7:0]  DISCARD_DFLT     = 8'h00;
  localparam logic [7:0]  AVERAGE_DFLT     = 8'h02;
  localparam int unsigned LOG_DEPTH        = 999;
  localparam int unsigned LOG_AW           = 10;
  localparam int unsigned VAL_W            = 24;
  localparam int unsigned SEC_W            = 14;
  localparam logic [7:0]  CYCLE_FIRST      = 8'h41;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    CCS_MODE_OTHER,
    CCS_MODE_QUICK,
    CCS_MODE_COOL
  } ccs_mode_t;

  typedef struct packed {
    ccs_mode_t   mode;
    logic        auto_range;
    logic        resistive_time_constant;
    logic        auto_zero;
    logic        comparator_on;
    logic        temp_comp_on;
    logic        per_length_scaling;
    logic [13:0] interval_s;
    logic [13:0] end_time_s;
    logic [7:0]  discard_n;
    logic [7:0]  average_n;
  } ccs_cfg_t;

  typedef struct packed {
    logic        start_key;
    logic        stop_key;
    logic        zero_key;
    logic        load_key;
    logic        load_plc;
    logic        load_serial;
    logic        print_req;
    logic        range_change;
  } ccs_keys_t;

  typedef struct packed {
    logic [LOG_AW-1:0] seq_num;
    logic [13:0]       elapsed_since_unload;
    logic [23:0]       value;
    logic [7:0]        cycle_letter;
  } ccs_entry_t;

endpackage

// >>> logic/ccs_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - Quick measure takes one reading in about 240 ms.
// - Quick measure needs manual range, resistive time constant and manual zero.
// - Cooling curve accepts any time constant and either zero method.
// - Cooling curve refused with comparator, autorange or temp comp; scaling ignored.
// - Range changes blocked during an active resistive cooling run.
// - Sample interval in whole seconds sets spacing of points, default 1 s.
// - Interval must be strictly shorter than end time, else rejected.
// - Run ends once end time, default 100 s, has elapsed.
// - A set number of first readings after start is discarded.
// - Each point is mean of a set number of readings, default two.
// - Load-removed command starts the elapsed-time run timer.
// - Load-removed command clears the data logger.
// - Load-removed also accepted from PLC input or serial host.
// - Zero key starts zero offset procedure while waiting.
// - Start begins readings; auto zero delays first reading a quarter second.
// - Logger holds at most 999 points.
// - One stop pauses the series; start resumes it.
// - Each resumed series gets the next cycle letter, starting at A.
// - Double stop or end time expiry ends the run into review.
// - Entry holds sequence number, elapsed time, value and cycle letter.
// - With printer selected the whole logger table can be printed.
module ccs_sequencer
  import ccs_pkg::*;
#(
  parameter int unsigned SEC_CYC   = SECOND_CYC,
  parameter int unsigned QUICK_CYC = QUICK_MEAS_CYC,
  parameter int unsigned ZDLY_CYC  = ZERO_DELAY_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire ccs_cfg_t          cfg,
  input  wire ccs_keys_t         keys_async,
  input  wire logic              printer_selected,
  input  wire logic              reading_valid,
  input  wire logic [VAL_W-1:0]  reading_value,
  input  wire logic [LOG_AW-1:0] view_index,
  output logic                   cfg_rejected,
  output logic                   range_locked,
  output logic                   meas_enable,
  output logic                   zero_start,
  output logic                   quick_done,
  output logic                   run_active,
  output logic                   in_review,
  output logic [SEC_W-1:0]       elapsed_s,
  output logic [LOG_AW-1:0]      log_count,
  output ccs_entry_t             view_entry,
  output logic                   print_valid,
  output ccs_entry_t             print_entry
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_QUICK,
    ST_WAIT_UNLOAD,
    ST_ARMED,
    ST_ZERO_DLY,
    ST_RUN,
    ST_PAUSE,
    ST_REVIEW
  } ccs_state_t;

  typedef struct packed {
    ccs_state_t        st;
    ccs_keys_t         k1;
    ccs_keys_t         k2;
    ccs_keys_t         kp;
    logic [31:0]       tick;
    logic [31:0]       dly;
    logic [SEC_W-1:0]  secs;
    logic [SEC_W-1:0]  ivl;
    logic              timing;
    logic              point_due;
    logic [7:0]        discarded;
    logic [7:0]        n_avg;
    logic [31:0]       acc;
    logic [7:0]        letter;
    logic              resumed;
    logic              stop_once;
    logic [LOG_AW-1:0] count;
    logic              wr;
    ccs_entry_t        wr_entry;
    logic              printing;
    logic [LOG_AW-1:0] pidx;
    logic              cfg_rejected;
    logic              range_locked;
    logic              meas_enable;
    logic              zero_start;
    logic              quick_done;
    logic              print_valid;
    logic              in_review;
    ccs_entry_t        view_entry;
    ccs_entry_t        print_entry;
  } ccs_regs_t;

  ccs_regs_t  r_q;
  ccs_regs_t  r_d;
  ccs_keys_t  kr;
  ccs_entry_t log_mem [LOG_DEPTH];
  logic       cool_ok;
  logic       quick_ok;
  logic       cfg_ok;
  logic       load_cmd;
  logic       due_tick;

  // ==========================================================================
  // Key edge detection, after the two-stage synchroniser
  // ==========================================================================
  always_comb begin
    kr = r_q.k2 & ~r_q.kp;
  end

  // All three sources of the unload command are treated alike
  assign load_cmd = kr.load_key | kr.load_plc | kr.load_serial;
  assign quick_ok = !cfg.auto_range && cfg.resistive_time_constant && !cfg.auto_zero;
  // Any time constant and zero method; scaling plays no part here
  assign cool_ok  = !cfg.comparator_on && !cfg.auto_range && !cfg.temp_comp_on;
  assign cfg_ok   = (cfg.mode == CCS_MODE_QUICK) ? quick_ok :
                    (cfg.mode == CCS_MODE_COOL)  ? (cool_ok &&
                    (cfg.interval_s != '0) && (cfg.interval_s < cfg.end_time_s)) : 1'b1;
  // A point falls due on the tick that closes an interval
  assign due_tick = r_q.timing && (r_q.tick == SEC_CYC - 1) &&
                    (r_q.ivl == cfg.interval_s - 1'b1);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    r_d             = r_q;
    r_d.k1          = keys_async;
    r_d.k2          = r_q.k1;
    r_d.kp          = r_q.k2;
    r_d.wr          = 1'b0;
    r_d.zero_start  = 1'b0;
    r_d.quick_done  = 1'b0;
    r_d.print_valid = 1'b0;
    r_d.cfg_rejected = !cfg_ok;
    // Registered read: view_entry follows view_index one clock later
    r_d.view_entry  = log_mem[view_index];

    // Run timer: whole seconds since unload
    if (r_q.timing) begin
      if (r_q.tick == SEC_CYC - 1) begin
        r_d.tick = '0;
        r_d.secs = r_q.secs + 1'b1;
        if (r_q.ivl == cfg.interval_s - 1'b1) begin
          r_d.ivl       = '0;
          r_d.point_due = 1'b1;
        end else begin
          r_d.ivl = r_q.ivl + 1'b1;
        end
      end else begin
        r_d.tick = r_q.tick + 1'b1;
      end
    end

    unique case (r_q.st)
      ST_IDLE: begin
        r_d.meas_enable = 1'b0;
        if (cfg_ok && cfg.mode == CCS_MODE_QUICK && kr.start_key) begin
          r_d.st          = ST_QUICK;
          r_d.dly         = '0;
          r_d.meas_enable = 1'b1;
        end else if (cfg_ok && cfg.mode == CCS_MODE_COOL) begin
          r_d.st = ST_WAIT_UNLOAD;
        end
      end
      // Fixed-length reading; the front end sees meas_enable as its window
      ST_QUICK: begin
        r_d.dly = r_q.dly + 1'b1;
        if (r_q.dly == QUICK_CYC - 1) begin
          r_d.meas_enable = 1'b0;
          r_d.quick_done  = 1'b1;
          r_d.st          = ST_IDLE;
        end
      end
      // Waiting states: zeroing, unload command, start and table print
      ST_WAIT_UNLOAD, ST_ARMED, ST_REVIEW: begin
        if (kr.zero_key && !cfg.auto_zero) begin
          r_d.zero_start = 1'b1;
        end
        if (!cfg_ok || cfg.mode != CCS_MODE_COOL) begin
          r_d.st     = ST_IDLE;
          r_d.timing = 1'b0;
        end else if (load_cmd) begin
          r_d.st        = ST_ARMED;
          r_d.timing    = 1'b1;
          r_d.tick      = '0;
          r_d.secs      = '0;
          r_d.ivl       = '0;
          r_d.point_due = 1'b0;
          r_d.count     = '0;
          r_d.letter    = CYCLE_FIRST;
          r_d.resumed   = 1'b0;
          r_d.printing  = 1'b0;
        end else if (r_q.st == ST_ARMED && kr.start_key) begin
          r_d.st          = cfg.auto_zero ? ST_ZERO_DLY : ST_RUN;
          r_d.dly         = '0;
          r_d.meas_enable = !cfg.auto_zero;
          r_d.discarded   = '0;
          r_d.n_avg       = '0;
          r_d.acc         = '0;
          r_d.stop_once   = 1'b0;
        end else if (r_q.st == ST_REVIEW && kr.print_req && printer_selected) begin
          r_d.printing = 1'b1;
          r_d.pidx     = '0;
        end
      end
      // Test current stays off while the zero reading is taken
      ST_ZERO_DLY: begin
        r_d.dly = r_q.dly + 1'b1;
        if (r_q.dly == ZDLY_CYC - 1) begin
          r_d.st          = ST_RUN;
          r_d.meas_enable = 1'b1;
        end
      end
      ST_RUN: begin
        if (reading_valid) begin
          if (r_q.discarded < cfg.discard_n) begin
            r_d.discarded = r_q.discarded + 1'b1;
          end else if (r_q.point_due) begin
            r_d.acc   = r_q.acc + 32'(reading_value);
            r_d.n_avg = r_q.n_avg + 1'b1;
            if (r_q.n_avg + 1'b1 >= cfg.average_n) begin
              // A point falling due in this very cycle wins over the clear
              r_d.point_due = due_tick;
              r_d.n_avg     = '0;
              r_d.acc       = '0;
              if (r_q.count < LOG_AW'(LOG_DEPTH)) begin
                r_d.wr                            = 1'b1;
                r_d.count                         = r_q.count + 1'b1;
                r_d.wr_entry.seq_num              = r_q.count + 1'b1;
                r_d.wr_entry.elapsed_since_unload = r_q.secs;
                r_d.wr_entry.value                = VAL_W'((r_q.acc + 32'(reading_value))
                                                    / ((cfg.average_n == '0) ? 32'd1
                                                    : 32'(cfg.average_n)));
                r_d.wr_entry.cycle_letter         = r_q.letter;
              end
            end
          end
        end
        if (kr.stop_key) begin
          r_d.st          = ST_PAUSE;
          r_d.meas_enable = 1'b0;
          r_d.stop_once   = 1'b1;
        end
      end
      // A point due while paused waits; further ones are not queued
      ST_PAUSE: begin
        if (kr.stop_key && r_q.stop_once) begin
          r_d.st     = ST_REVIEW;
          r_d.timing = 1'b0;
        end else if (kr.start_key) begin
          r_d.st          = ST_RUN;
          r_d.meas_enable = 1'b1;
          r_d.stop_once   = 1'b0;
          r_d.letter      = r_q.letter + 1'b1;
          r_d.discarded   = '0;
          r_d.n_avg       = '0;
          r_d.acc         = '0;
        end
      end
    endcase

    // End time ends the run wherever it stands
    if (r_q.timing && r_q.secs >= cfg.end_time_s &&
        (r_q.st == ST_RUN || r_q.st == ST_PAUSE || r_q.st == ST_ZERO_DLY ||
         r_q.st == ST_ARMED)) begin
      r_d.st          = ST_REVIEW;
      r_d.timing      = 1'b0;
      r_d.meas_enable = 1'b0;
      r_d.point_due   = 1'b0;
    end

    // Settings made illegal mid-run drop the run rather than log under them
    if ((!cfg_ok || cfg.mode != CCS_MODE_COOL) &&
        (r_q.st == ST_RUN || r_q.st == ST_PAUSE || r_q.st == ST_ZERO_DLY)) begin
      r_d.st          = ST_IDLE;
      r_d.timing      = 1'b0;
      r_d.meas_enable = 1'b0;
      r_d.point_due   = 1'b0;
    end

    // Table print walks every entry, one per clock
    if (r_q.printing) begin
      r_d.print_valid = 1'b1;
      r_d.print_entry = log_mem[r_q.pidx];
      r_d.pidx        = r_q.pidx + 1'b1;
      if (r_q.pidx + 1'b1 >= r_q.count) begin
        r_d.printing = 1'b0;
      end
    end
    if (r_q.printing && r_q.count == '0) begin
      r_d.printing    = 1'b0;
      r_d.print_valid = 1'b0;
    end

    // Taken from the next state so the lock rises together with the run
    r_d.range_locked = cfg.resistive_time_constant &&
                       (r_d.st == ST_RUN || r_d.st == ST_PAUSE || r_d.st == ST_ZERO_DLY);
    r_d.in_review    = (r_d.st == ST_REVIEW);
  end

  // ==========================================================================
  // Registers and logger memory
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r_q        <= '0;
      r_q.st     <= ST_IDLE;
      r_q.letter <= CYCLE_FIRST;
    end else begin
      r_q <= r_d;
    end
  end

  // Memory stays outside reset; the count alone says which entries hold data
  always_ff @(posedge sys_clk) begin
    if (r_q.wr) begin
      log_mem[r_q.wr_entry.seq_num - 1'b1] <= r_q.wr_entry;
    end
  end

  assign cfg_rejected = r_q.cfg_rejected;
  assign range_locked = r_q.range_locked;
  assign meas_enable  = r_q.meas_enable;
  assign zero_start   = r_q.zero_start;
  assign quick_done   = r_q.quick_done;
  assign run_active   = r_q.timing;
  assign in_review    = r_q.in_review;
  assign elapsed_s    = r_q.secs;
  assign log_count    = r_q.count;
  assign view_entry   = r_q.view_entry;
  assign print_valid  = r_q.print_valid;
  assign print_entry  = r_q.print_entry;

endmodule

// >>> testbench/ccs_sequencer_asserts.sv
`timescale 1ns/1ps
module ccs_sequencer_asserts
  import ccs_pkg::*;
#(
  parameter int unsigned SEC_CYC   = SECOND_CYC,
  parameter int unsigned QUICK_CYC = QUICK_MEAS_CYC,
  parameter int unsigned ZDLY_CYC  = ZERO_DELAY_CYC
) (
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire ccs_cfg_t          cfg,
  input wire ccs_keys_t         keys_async,
  input wire logic              printer_selected,
  input wire logic              reading_valid,
  input wire logic [VAL_W-1:0]  reading_value,
  input wire logic [LOG_AW-1:0] view_index,
  input wire logic              cfg_rejected,
  input wire logic              range_locked,
  input wire logic              meas_enable,
  input wire logic              zero_start,
  input wire logic              quick_done,
  input wire logic              run_active,
  input wire logic              in_review,
  input wire logic [SEC_W-1:0]  elapsed_s,
  input wire logic [LOG_AW-1:0] log_count,
  input wire ccs_entry_t        view_entry,
  input wire logic              print_valid,
  input wire ccs_entry_t        print_entry
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Settings gates
  // ==========================================================================
  wire logic cool_bad = cfg.mode == CCS_MODE_COOL
                        && (cfg.comparator_on || cfg.auto_range || cfg.temp_comp_on);
  wire logic ivl_bad  = cfg.mode == CCS_MODE_COOL && cfg.interval_s >= cfg.end_time_s;
  // Counts quick-mode measuring cycles; the full length is far too long to unroll
  logic [31:0] q_run;
  always_ff @(posedge sys_clk) begin
    if (reset || quick_done) begin
      q_run <= '0;
    end else if (meas_enable && cfg.mode == CCS_MODE_QUICK) begin
      q_run <= q_run + 1'b1;
    end
  end
  chk_quick_time: assert property (quick_done |-> q_run == QUICK_CYC && !meas_enable)
    else $error("quick measure length wrong");
  chk_quick_gate: assert property (quick_done
    |-> !cfg.auto_range && cfg.resistive_time_constant && !cfg.auto_zero)
    else $error("quick measure ran with illegal settings");
  chk_cool_refuse: assert property (cool_bad [*2] |-> cfg_rejected && !run_active)
    else $error("forbidden cooling settings accepted");
  chk_interval_short: assert property (ivl_bad [*2] |-> cfg_rejected)
    else $error("interval not below end time accepted");
  // ==========================================================================
  // Run behaviour
  // ==========================================================================
  chk_range_lock: assert property (run_active && meas_enable && cfg.resistive_time_constant
    |-> range_locked)
    else $error("range not locked during run");
  chk_log_depth: assert property (log_count <= LOG_DEPTH) else $error("logger overfilled");
  chk_end_time: assert property (run_active |-> elapsed_s <= cfg.end_time_s)
    else $error("run went past end time");
  chk_review_quiet: assert property (in_review |-> !meas_enable)
    else $error("readings wanted in review");
  chk_zero_wait: assert property (zero_start |-> !run_active && !cfg.auto_zero)
    else $error("zero start outside waiting");
  chk_print_gate: assert property (print_valid |-> printer_selected && in_review)
    else $error("print outside review or without printer");
  chk_elapsed_step: assert property (run_active ##1 run_active
    |-> elapsed_s == $past(elapsed_s) || elapsed_s == $past(elapsed_s) + 14'h0001)
    else $error("elapsed seconds jumped");
  cov_quick: cover property (quick_done);
  cov_review: cover property ($rose(in_review));
  cov_print: cover property (print_valid);
  cov_zero: cover property (zero_start);
endmodule

bind ccs_sequencer ccs_sequencer_asserts #(
  .SEC_CYC(SEC_CYC), .QUICK_CYC(QUICK_CYC), .ZDLY_CYC(ZDLY_CYC)
) chk (
  .sys_clk, .reset, .cfg, .keys_async, .printer_selected, .reading_valid, .reading_value,
  .view_index, .cfg_rejected, .range_locked, .meas_enable, .zero_start, .quick_done,
  .run_active, .in_review, .elapsed_s, .log_count, .view_entry, .print_valid, .print_entry
);

// >>> testbench/ccs_panel.sv
`timescale 1ns/1ps
module ccs_panel
  import ccs_pkg::*;
(
  input  wire logic sys_clk,
  output ccs_keys_t keys
);
  initial keys = '0;
  // ==========================================================================
  // Key presses
  // ==========================================================================
  // Held four cycles so the two-flop synchroniser cannot miss a press;
  // PLC and serial load-removed bits are pulsed the same way as the panel key
  task automatic press(input int k);
    @(posedge sys_clk);
    keys[k] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    keys[k] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// >>> testbench/ccs_sequencer_test.sv
`timescale 1ns/1ps
module ccs_sequencer_test;
  import ccs_pkg::*;
  localparam int unsigned QCK = 10;
  localparam int K_START = 7, K_STOP = 6, K_ZERO = 5, K_LOAD = 4, K_PLC = 3, K_SER = 2;
  localparam int K_PRINT = 1;
  localparam ccs_cfg_t COOL0 = '{mode: CCS_MODE_COOL, resistive_time_constant: 1'b1,
    interval_s: 14'h0002, end_time_s: 14'h0008, discard_n: 8'h01,
    average_n: AVERAGE_DFLT, default: '0};
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  ccs_cfg_t          cfg = COOL0;
  ccs_keys_t         keys;
  logic              printer_selected = 1'b0;
  logic              reading_valid = 1'b0;
  logic [VAL_W-1:0]  reading_value = 24'h000000;
  logic [VAL_W-1:0]  base = 24'h000100;
  logic [LOG_AW-1:0] view_index = 10'h000;
  logic              cfg_rejected, range_locked, meas_enable, zero_start, quick_done;
  logic              run_active, in_review, print_valid;
  logic [SEC_W-1:0]  elapsed_s;
  logic [LOG_AW-1:0] log_count;
  ccs_entry_t        view_entry, print_entry;
  int                error_cnt = 0, num_checks = 0, rd_cnt = 0;
  int                me_cnt = 0, zs_cnt = 0, pv_cnt = 0;

  initial forever #2.5 sys_clk = ~sys_clk;
  ccs_panel panel (.sys_clk(sys_clk), .keys(keys));
  ccs_sequencer #(.SEC_CYC(20), .QUICK_CYC(QCK), .ZDLY_CYC(5)) uut (
    .sys_clk(sys_clk), .reset(reset), .cfg(cfg), .keys_async(keys),
    .printer_selected(printer_selected), .reading_valid(reading_valid),
    .reading_value(reading_value), .view_index(view_index), .cfg_rejected(cfg_rejected),
    .range_locked(range_locked), .meas_enable(meas_enable), .zero_start(zero_start),
    .quick_done(quick_done), .run_active(run_active), .in_review(in_review),
    .elapsed_s(elapsed_s), .log_count(log_count), .view_entry(view_entry),
    .print_valid(print_valid), .print_entry(print_entry));
  // ==========================================================================
  // Front end: a reading every third cycle, the first of a series unsettled
  // ==========================================================================
  always @(posedge sys_clk) begin
    rd_cnt <= meas_enable ? rd_cnt + 1 : 0;
    reading_valid <= meas_enable && rd_cnt % 3 == 2;
    reading_value <= (rd_cnt < 3) ? 24'h000fff : base;
    me_cnt <= me_cnt + int'(meas_enable === 1'b1);
    zs_cnt <= zs_cnt + int'(zero_start === 1'b1);
    pv_cnt <= pv_cnt + int'(print_valid === 1'b1);
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic t_cfg(input ccs_cfg_t c, input logic exp);
    cyc(1);
    cfg <= c;
    cyc(3);
    @(negedge sys_clk);
    chk("cfg_rejected", 32'(exp), 32'(cfg_rejected));
  endtask
  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_quick();
    ccs_cfg_t c;
    int       m0, n, seen;
    c = COOL0;
    c.mode = CCS_MODE_QUICK;
    t_cfg(c, 1'b0);
    m0 = me_cnt;
    panel.press(K_START);
    for (n = 0; n < 60 && quick_done !== 1'b1; n++) @(negedge sys_clk);
    chk("quick meas_enable cycles", QCK, me_cnt - m0);
    c.auto_range = 1'b1;
    t_cfg(c, 1'b1);
    panel.press(K_START);
    seen = 0;
    for (n = 0; n < 40; n++) begin
      @(negedge sys_clk);
      if (quick_done === 1'b1) seen = 1;
    end
    chk("quick with autorange", 0, seen);
  endtask
  task automatic t_reject();
    ccs_cfg_t c;
    c = COOL0; c.comparator_on = 1'b1; t_cfg(c, 1'b1);
    c = COOL0; c.auto_range = 1'b1; t_cfg(c, 1'b1);
    c = COOL0; c.temp_comp_on = 1'b1; t_cfg(c, 1'b1);
    c = COOL0; c.interval_s = 14'h0008; t_cfg(c, 1'b1);
    c = COOL0; c.interval_s = 14'h0007; t_cfg(c, 1'b0);
    c = COOL0; c.resistive_time_constant = 1'b0; c.auto_zero = 1'b1;
    c.per_length_scaling = 1'b1; t_cfg(c, 1'b0);
  endtask
  task automatic t_cool();
    ccs_cfg_t c;
    int       n, z0, p0, m0;
    t_cfg(COOL0, 1'b0);
    z0 = zs_cnt;
    panel.press(K_ZERO);
    @(negedge sys_clk);
    chk("zero_start pulses", 1, zs_cnt - z0);
    panel.press(K_LOAD);
    @(negedge sys_clk);
    chk("run_active after load", 1, 32'(run_active));
    panel.press(K_START);
    cyc(60);
    @(negedge sys_clk);
    chk("range_locked", 1, 32'(range_locked));
    panel.press(K_STOP);
    base <= 24'h000200;
    panel.press(K_START);
    for (n = 0; n < 400 && in_review !== 1'b1; n++) @(negedge sys_clk);
    chk("review at end time", 1, 32'(in_review));
    chk("elapsed at end", 8, 32'(elapsed_s));
    chk("points logged", 3, 32'(log_count));
    cyc(1);
    view_index <= 10'h000;
    cyc(2);
    @(negedge sys_clk);
    chk("first seq", 1, 32'(view_entry.seq_num));
    chk("first elapsed", 2, 32'(view_entry.elapsed_since_unload));
    chk("first value", 32'h100, 32'(view_entry.value));
    chk("first letter", 32'h41, 32'(view_entry.cycle_letter));
    cyc(1);
    view_index <= 10'h002;
    printer_selected <= 1'b1;
    cyc(2);
    @(negedge sys_clk);
    chk("last seq", 3, 32'(view_entry.seq_num));
    chk("last elapsed", 6, 32'(view_entry.elapsed_since_unload));
    chk("last value", 32'h200, 32'(view_entry.value));
    chk("last letter", 32'h42, 32'(view_entry.cycle_letter));
    p0 = pv_cnt;
    panel.press(K_PRINT);
    cyc(8);
    chk("printed entries", 3, pv_cnt - p0);
    chk("last printed value", 32'h200, 32'(print_entry.value));
    panel.press(K_PLC);
    @(negedge sys_clk);
    chk("log cleared", 0, 32'(log_count));
    panel.press(K_START);
    for (n = 0; n < 2; n++) panel.press(K_STOP);
    @(negedge sys_clk);
    chk("review after double stop", 1, 32'(in_review));
    panel.press(K_SER);
    @(negedge sys_clk);
    chk("serial load restarts", 1, 32'(run_active));
    c = COOL0;
    c.auto_zero = 1'b1;
    t_cfg(c, 1'b0);
    m0 = me_cnt;
    panel.press(K_START);
    @(negedge sys_clk);
    chk("meas_enable during zero delay", 0, me_cnt - m0);
    chk("meas_enable after zero delay", 1, 32'(meas_enable));
  endtask

  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    cyc(4);
    t_quick();
    t_reject();
    t_cool();
    test_done();
  end
endmodule
